// >>> hw/tae_alert_bank.sv
// Alert-enable mask, limit thresholds, event flags and the alert pin driver
//
// Behaviour
// [RULE_01] A disabled source never drives the alert pin active by setting its flag.
// [RULE_02] An enabled source drives the alert pin active when its flag sets.
// [RULE_03] Every event flag is recorded whether or not its enable is set.
// [RULE_04] Active alert stays after enable clears, until status read or new conversion.
// [RULE_05] Enable register at offset 04h resets to 0016h.
// [RULE_06] Enable bit 4 gates the checksum error flag onto the alert.
// [RULE_07] Enable bit 3 gates slew flag, or live slew status in comparator mode.
// [RULE_08] Enable bit 2 gates over-limit flag, or live over-limit in comparator mode.
// [RULE_09] Enable bit 1 gates under-limit flag, or live under-limit in comparator mode.
// [RULE_10] Enable bit 0 gates the new-sample flag onto the alert.
// [RULE_11] Thresholds hold 14-bit two's complement in bits 15:2, 0.03125 degC steps.
// [RULE_12] Thresholds share the result encoding and compare with it directly.
// [RULE_13] Lower threshold at offset 05h resets to F380h, minus 25 degC.
// [RULE_14] Upper threshold at offset 06h resets to 2A80h, 85 degC.
// [RULE_15] Limits are ignored while upper threshold is not above lower threshold.
// [RULE_16] Threshold bits 1:0 are read-only and always read 00b.
// [RULE_17] Mode input low selects latched interrupt mode, high selects comparator mode.
// [RULE_18] New-sample flag clears on a status read or a result read.
// [RULE_19] Release points are threshold minus or plus margin, 0.5 degC per step.
// [RULE_20] Alert is the OR of enabled sources; reserved bits ignore writes, read zero.
// [RULE_21] Each finished conversion is compared with both thresholds to update limits.
`timescale 1ns/1ps
module tae_alert_bank #(
    parameter int THR_W = tae_pkg::TAE_THR_W,
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Register access from the serial interface block
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic reg_hit_o,
    // Conversion engine and event sources
    input wire logic conv_done_i,
    input wire logic [15:0] temp_result_i,
    input wire logic crc_err_i,
    input wire logic slew_event_i,
    input wire logic slew_live_i,
    // Mode and release margins from neighbouring registers
    input wire logic comp_mode_i,
    input wire logic [7:0] upper_release_margin_i,
    input wire logic [7:0] lower_release_margin_i,
    // Reads elsewhere that clear flags
    input wire logic status_read_i,
    input wire logic result_read_i,
    // Flags and live status for the status register
    output logic [tae_pkg::TAE_SRC_N-1:0] event_flags_o,
    output logic over_limit_live_o,
    output logic under_limit_live_o,
    output logic limits_valid_o,
    // Alert pin, active low
    output logic alert_n_o
);
    localparam int SRC_N = tae_pkg::TAE_SRC_N;

    // ==========================================================
    // Elaboration checks
    if (THR_W != tae_pkg::TAE_THR_W) begin : g_bad_thr_w
        $error("Threshold width must be 14");
    end
    if (ADDR_W < 3) begin : g_bad_addr_w
        $error("Address width too small for offsets 4 to 6");
    end
    if (SRC_N > 16) begin : g_bad_src_n
        $error("More event sources than enable bits");
    end

    // ==========================================================
    // Register file state
    logic [15:0] enable_q, enable_d;
    logic [15:0] lower_q, lower_d;
    logic [15:0] upper_q, upper_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic sel_enable, sel_lower, sel_upper;

    // Address decode of the three offsets
    always_comb begin
        sel_enable = reg_addr_i == ADDR_W'(tae_pkg::TAE_OFS_ENABLE);
        sel_lower = reg_addr_i == ADDR_W'(tae_pkg::TAE_OFS_LOWER);
        sel_upper = reg_addr_i == ADDR_W'(tae_pkg::TAE_OFS_UPPER);
        reg_hit_o = sel_enable | sel_lower | sel_upper;
    end

    // Writes keep only writable bits; reads return a masked copy
    always_comb begin
        enable_d = enable_q;
        lower_d = lower_q;
        upper_d = upper_q;
        rdata_d = rdata_q;
        rvalid_d = reg_rd_i;
        if (reg_wr_i && sel_enable) begin
            enable_d = reg_wdata_i & tae_pkg::TAE_ENABLE_MASK; // see [RULE_20]
        end
        if (reg_wr_i && sel_lower) begin
            lower_d = reg_wdata_i & tae_pkg::TAE_THR_MASK; // see [RULE_11] [RULE_16]
        end
        if (reg_wr_i && sel_upper) begin
            upper_d = reg_wdata_i & tae_pkg::TAE_THR_MASK; // see [RULE_11] [RULE_16]
        end
        if (reg_rd_i) begin
            if (sel_enable) begin
                rdata_d = enable_q;
            end else if (sel_lower) begin
                rdata_d = lower_q;
            end else if (sel_upper) begin
                rdata_d = upper_q;
            end else begin
                rdata_d = 16'h0000;
            end
        end
    end

    // Register file flip-flops
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_q <= tae_pkg::TAE_RST_ENABLE; // see [RULE_05]
            lower_q <= tae_pkg::TAE_RST_LOWER; // see [RULE_13]
            upper_q <= tae_pkg::TAE_RST_UPPER; // see [RULE_14]
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            enable_q <= enable_d;
            lower_q <= lower_d;
            upper_q <= upper_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // ==========================================================
    // Limit comparison
    logic over_live_q, over_live_d;
    logic under_live_q, under_live_d;
    logic over_cmp, under_cmp;

    // Next live status for the present result
    tae_limit_cmp u_cmp (
        .temp_i(temp_result_i),
        .upper_thr_i(upper_q),
        .lower_thr_i(lower_q),
        .upper_release_margin_i(upper_release_margin_i),
        .lower_release_margin_i(lower_release_margin_i),
        .over_live_i(over_live_q),
        .under_live_i(under_live_q),
        .over_live_d_o(over_cmp),
        .under_live_d_o(under_cmp),
        .limits_valid_o(limits_valid_o)
    );

    // Live status moves only when a conversion finishes
    always_comb begin
        over_live_d = over_live_q;
        under_live_d = under_live_q;
        if (conv_done_i) begin
            over_live_d = over_cmp; // see [RULE_21]
            under_live_d = under_cmp; // see [RULE_21]
        end
    end

    // Live status flip-flops
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            over_live_q <= 1'b0;
            under_live_q <= 1'b0;
        end else begin
            over_live_q <= over_live_d;
            under_live_q <= under_live_d;
        end
    end

    assign over_limit_live_o = over_live_q;
    assign under_limit_live_o = under_live_q;

    // ==========================================================
    // Event flags
    logic [SRC_N-1:0] flag_q, flag_d;
    logic [SRC_N-1:0] flag_set, flag_clr;

    // Set and clear causes per source
    always_comb begin
        flag_set = '0;
        flag_set[tae_pkg::TAE_SRC_CRC] = crc_err_i;
        flag_set[tae_pkg::TAE_SRC_SLEW] = slew_event_i;
        flag_set[tae_pkg::TAE_SRC_UPPER] = conv_done_i & over_cmp & ~over_live_q;
        flag_set[tae_pkg::TAE_SRC_LOWER] = conv_done_i & under_cmp & ~under_live_q;
        flag_set[tae_pkg::TAE_SRC_READY] = conv_done_i;
        flag_clr = {SRC_N{status_read_i}};
        flag_clr[tae_pkg::TAE_SRC_READY] = status_read_i | result_read_i; // see [RULE_18]
        // Set wins over a clear in the same cycle; enable plays no part here
        flag_d = (flag_q & ~flag_clr) | flag_set; // see [RULE_03]
    end

    // Flag flip-flops
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign event_flags_o = flag_q;

    // ==========================================================
    // Alert source selection
    logic [SRC_N-1:0] live_vec;
    logic [SRC_N-1:0] src_vec;
    logic [SRC_N-1:0] live_capable;
    logic [SRC_N-1:0] gate_vec;

    // Live sources exist for slew, upper and lower only
    always_comb begin
        live_vec = '0;
        live_vec[tae_pkg::TAE_SRC_SLEW] = slew_live_i; // see [RULE_07]
        live_vec[tae_pkg::TAE_SRC_UPPER] = over_live_d; // see [RULE_08]
        live_vec[tae_pkg::TAE_SRC_LOWER] = under_live_d; // see [RULE_09]
        live_capable = '0;
        live_capable[tae_pkg::TAE_SRC_SLEW] = 1'b1;
        live_capable[tae_pkg::TAE_SRC_UPPER] = 1'b1;
        live_capable[tae_pkg::TAE_SRC_LOWER] = 1'b1;
    end

    // Enable bits of the five sources; reserved bits above play no part
    assign gate_vec = enable_q[SRC_N-1:0]; // see [RULE_06] [RULE_10]

    // Each source gated by its own enable bit
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        logic use_live;
        // Comparator mode picks live status for slew, upper and lower; other sources and interrupt mode use the latched flag
        assign use_live = comp_mode_i && live_capable[i]; // see [RULE_17]
        assign src_vec[i] = gate_vec[i] & (use_live ? live_vec[i] : flag_d[i]); // see [RULE_01]
    end

    // ==========================================================
    // Alert pin
    logic alert_q, alert_d;

    // OR of enabled sources; a held alert drops only on status read or new result
    always_comb begin
        alert_d = (|src_vec) |
            (alert_q & ~(status_read_i | conv_done_i)); // see [RULE_02] [RULE_04] [RULE_20]
    end

    // Alert flip-flop
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
        end
    end

    assign alert_n_o = ~alert_q;
endmodule

// >>> hw/tae_pkg.sv
// Package of offsets, field positions and reset values for the alert-enable and threshold bank
package tae_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [3:0] TAE_OFS_ENABLE = 4'h4;
    localparam logic [3:0] TAE_OFS_LOWER = 4'h5;
    localparam logic [3:0] TAE_OFS_UPPER = 4'h6;

    // ==========================================================
    // Reset values
    localparam logic [15:0] TAE_RST_ENABLE = 16'h0016;
    localparam logic [15:0] TAE_RST_LOWER = 16'hF380;
    localparam logic [15:0] TAE_RST_UPPER = 16'h2A80;

    // ==========================================================
    // Event source positions in the enable mask and flag vector
    localparam int TAE_SRC_N = 5;
    localparam int TAE_SRC_CRC = 4;
    localparam int TAE_SRC_SLEW = 3;
    localparam int TAE_SRC_UPPER = 2;
    localparam int TAE_SRC_LOWER = 1;
    localparam int TAE_SRC_READY = 0;
    localparam logic [15:0] TAE_ENABLE_MASK = 16'h001F;

    // ==========================================================
    // Threshold field layout: 14-bit value in bits 15:2, bits 1:0 read zero
    localparam int TAE_THR_W = 14;
    localparam int TAE_THR_LSB = 2;
    localparam logic [15:0] TAE_THR_MASK = 16'hFFFC;
    // Release margin step of 0.5 degC equals 16 threshold steps
    localparam int TAE_MARGIN_SHIFT = 4;
endpackage

// >>> hw/tae_limit_cmp.sv
// Limit comparator: next over/under live status from a new result and the thresholds
`timescale 1ns/1ps
module tae_limit_cmp (
    // Result and thresholds, 14-bit two's complement in bits 15:2
    input wire logic [15:0] temp_i,
    input wire logic [15:0] upper_thr_i,
    input wire logic [15:0] lower_thr_i,
    // Release margins, unsigned, 0.5 degC per step
    input wire logic [7:0] upper_release_margin_i,
    input wire logic [7:0] lower_release_margin_i,
    // Present live status
    input wire logic over_live_i,
    input wire logic under_live_i,
    // Next live status and limit validity
    output logic over_live_d_o,
    output logic under_live_d_o,
    output logic limits_valid_o
);
    logic signed [15:0] temp_s;
    logic signed [15:0] upper_s;
    logic signed [15:0] lower_s;
    logic signed [15:0] upper_rel_s;
    logic signed [15:0] lower_rel_s;

    // Sign-extend the fields; same encoding means no scaling is needed (see [RULE_12])
    always_comb begin
        temp_s = {{2{temp_i[15]}}, temp_i[15:tae_pkg::TAE_THR_LSB]};
        upper_s = {{2{upper_thr_i[15]}}, upper_thr_i[15:tae_pkg::TAE_THR_LSB]};
        lower_s = {{2{lower_thr_i[15]}}, lower_thr_i[15:tae_pkg::TAE_THR_LSB]};
        upper_rel_s = upper_s - signed'({4'h0, upper_release_margin_i, 4'h0}); // see [RULE_19]
        lower_rel_s = lower_s + signed'({4'h0, lower_release_margin_i, 4'h0}); // see [RULE_19]
    end

    // Set at the threshold, release past the margin, hold in between
    always_comb begin
        limits_valid_o = upper_s > lower_s; // see [RULE_15]
        if (!limits_valid_o) begin
            over_live_d_o = 1'b0;
            under_live_d_o = 1'b0;
        end else begin
            if (temp_s >= upper_s) begin
                over_live_d_o = 1'b1;
            end else if (temp_s < upper_rel_s) begin
                over_live_d_o = 1'b0;
            end else begin
                over_live_d_o = over_live_i;
            end
            if (temp_s <= lower_s) begin
                under_live_d_o = 1'b1;
            end else if (temp_s > lower_rel_s) begin
                under_live_d_o = 1'b0;
            end else begin
                under_live_d_o = under_live_i;
            end
        end
    end
endmodule

// >>> sim/tae_host_model.sv
// Host model: register writes and reads on the strobe port of the bank
`timescale 1ns/1ps
module tae_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Register port
    output logic [3:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    // ==========================================================
    // Idle bus at time zero
    initial begin
        reg_addr_o = 4'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end

    // One-cycle write; data inverted once released so stale data never matches
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
        #1; // Let the written register settle before the caller looks at outputs
    endtask

    // One-cycle read; answer taken while the valid pulse stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic v);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o <= 1'b0;
        #1;
        v = reg_rvalid_i;
        d = reg_rdata_i;
    endtask
endmodule

// >>> sim/tae_alert_bank_sva.sv
// Checker of register answers, event flags and the alert pin
`timescale 1ns/1ps
module tae_alert_bank_sva #(
    parameter int ADDR_W = 4
) (
    // Clock, reset and register port
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic reg_hit_o,
    // Events and flags
    input wire logic conv_done_i,
    input wire logic crc_err_i,
    input wire logic slew_event_i,
    input wire logic comp_mode_i,
    input wire logic status_read_i,
    input wire logic result_read_i,
    input wire logic [tae_pkg::TAE_SRC_N-1:0] event_flags_o,
    input wire logic over_limit_live_o,
    input wire logic under_limit_live_o,
    input wire logic limits_valid_o,
    input wire logic alert_n_o
);
    // ==========================================================
    // All checks on the system clock
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    rd_answer_a: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid not one cycle after strobe");
    addr_hit_a: assert property (reg_hit_o == (reg_addr_i >= 4 && reg_addr_i <= 6))
        else $error("address decode wrong");
    unmapped_zero_a: assert property (reg_rd_i && !reg_hit_o |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    thr_low_bits_a: assert property (reg_rd_i && reg_addr_i inside {5, 6} |=>
        reg_rdata_o[1:0] == 2'b00) else $error("threshold low bits not zero");
    crc_flag_a: assert property (crc_err_i |=> event_flags_o[4])
        else $error("checksum flag not recorded");
    ready_flag_a: assert property (conv_done_i |=> event_flags_o[0])
        else $error("ready flag not set by conversion");
    ready_clear_a: assert property (result_read_i && !conv_done_i |=> !event_flags_o[0])
        else $error("ready flag not cleared by result read");
    status_clear_a: assert property (status_read_i && !(crc_err_i || slew_event_i ||
        conv_done_i) |=> event_flags_o == '0) else $error("flags not cleared by status read");
    alert_release_a: assert property (status_read_i && !comp_mode_i && !(crc_err_i ||
        slew_event_i || conv_done_i) |=> alert_n_o) else $error("alert held after status read");
    limits_off_a: assert property (conv_done_i && !limits_valid_o |=>
        !over_limit_live_o && !under_limit_live_o) else $error("limits not ignored");
endmodule

bind tae_alert_bank tae_alert_bank_sva #(.ADDR_W(ADDR_W)) i_sva (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .reg_hit_o(reg_hit_o), .conv_done_i(conv_done_i), .crc_err_i(crc_err_i),
    .slew_event_i(slew_event_i), .comp_mode_i(comp_mode_i), .status_read_i(status_read_i),
    .result_read_i(result_read_i), .event_flags_o(event_flags_o),
    .over_limit_live_o(over_limit_live_o), .under_limit_live_o(under_limit_live_o),
    .limits_valid_o(limits_valid_o), .alert_n_o(alert_n_o));

// >>> sim/testbench.sv
// Self-checking bench of the alert-enable and threshold bank
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    // ==========================================================
    // Signals
    logic sys_clk_i = 1'b0, resetn_i = 1'b0, conv_done_i = 1'b0, crc_err_i = 1'b0;
    logic slew_event_i = 1'b0, slew_live_i = 1'b0, comp_mode_i = 1'b0;
    logic status_read_i = 1'b0, result_read_i = 1'b0, reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic reg_hit_o, over_limit_live_o, under_limit_live_o, limits_valid_o, alert_n_o;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, temp_result_i = 16'h0000;
    logic [7:0] margin = 8'h0A;
    logic [4:0] event_flags_o;
    logic [15:0] tmp [5] = '{16'h0000, 16'hF380, 16'h2A80, 16'h0000, 16'h0000};
    int failures = 0, checks_done = 0, cycles = 0;

    // Clock of 8 ns and cycle ceiling
    initial forever #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            report_and_stop();
        end
    end

    tae_host_model i_host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o));
    tae_alert_bank i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o),
        .conv_done_i(conv_done_i), .temp_result_i(temp_result_i), .crc_err_i(crc_err_i),
        .slew_event_i(slew_event_i), .slew_live_i(slew_live_i), .comp_mode_i(comp_mode_i),
        .upper_release_margin_i(margin), .lower_release_margin_i(margin),
        .status_read_i(status_read_i), .result_read_i(result_read_i),
        .event_flags_o(event_flags_o), .over_limit_live_o(over_limit_live_o),
        .under_limit_live_o(under_limit_live_o), .limits_valid_o(limits_valid_o),
        .alert_n_o(alert_n_o));

    // ==========================================================
    // Shared tasks: 0..2 conversions, 3 slew, 4 checksum, 5 status read, 6 result read
    task automatic fire(input int src, input logic [15:0] t);
        @(posedge sys_clk_i);
        temp_result_i <= t;
        conv_done_i <= (src < 3);
        slew_event_i <= (src == 3);
        crc_err_i <= (src == 4);
        status_read_i <= (src == 5);
        result_read_i <= (src == 6);
        @(posedge sys_clk_i);
        {conv_done_i, slew_event_i, crc_err_i, status_read_i, result_read_i} <= 5'h00;
        temp_result_i <= ~t;
        #1;
    endtask

    // Release live limits with a mid-range result, then clear flags
    task automatic clean();
        fire(0, 16'h0000);
        fire(5, 16'h0000);
        `CHK(alert_n_o, 1'b1)
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic v;
        i_host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk(4'h4, 16'h0016);
        rd_chk(4'h5, 16'hF380);
        rd_chk(4'h6, 16'h2A80);
        rd_chk(4'h7, 16'h0000);
        i_host.wr(4'h4, 16'hFFFF);
        rd_chk(4'h4, 16'h001F);
        i_host.wr(4'h5, 16'hFFFF);
        rd_chk(4'h5, 16'hFFFC);
        i_host.wr(4'h6, 16'h1237);
        rd_chk(4'h6, 16'h1234);
        i_host.wr(4'h5, 16'hF380);
        i_host.wr(4'h6, 16'h2A80);
        `CHK(limits_valid_o, 1'b1)
        $display("test registers done");
    endtask

    task automatic t_sources();
        for (int i = 0; i < 5; i++) begin
            i_host.wr(4'h4, 16'h0000);
            fire(i, tmp[i]);
            `CHK(event_flags_o[i], 1'b1)
            `CHK(alert_n_o, 1'b1)
            clean();
            i_host.wr(4'h4, 16'h0001 << i);
            fire(i, tmp[i]);
            `CHK(alert_n_o, 1'b0)
            clean();
        end
        fire(0, 16'h0000);
        fire(6, 16'h0000);
        `CHK(event_flags_o[0], 1'b0)
        $display("test sources done");
    endtask

    task automatic t_hold_comp();
        i_host.wr(4'h4, 16'h0010);
        fire(4, 16'h0000);
        i_host.wr(4'h4, 16'h0000);
        repeat (3) @(posedge sys_clk_i);
        #1;
        `CHK(alert_n_o, 1'b0)
        clean();
        @(posedge sys_clk_i);
        comp_mode_i <= 1'b1;
        i_host.wr(4'h4, 16'h0008);
        @(posedge sys_clk_i);
        slew_live_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        `CHK(alert_n_o, 1'b0)
        @(posedge sys_clk_i);
        slew_live_i <= 1'b0;
        clean();
        @(posedge sys_clk_i);
        comp_mode_i <= 1'b0;
        $display("test hold and comparator done");
    endtask

    task automatic t_invalid();
        i_host.wr(4'h6, 16'hF380);
        `CHK(limits_valid_o, 1'b0)
        i_host.wr(4'h4, 16'h0006);
        fire(2, 16'h2A80);
        `CHK({over_limit_live_o, event_flags_o[2:1]}, 3'b000)
        `CHK(alert_n_o, 1'b1)
        i_host.wr(4'h6, 16'h2A80);
        clean();
        $display("test invalid limits done");
    endtask

    // Release band in comparator mode: margin 4 is 2 degC, 64 steps, 0100h in the register
    task automatic t_margin();
        @(posedge sys_clk_i);
        margin <= 8'h04;
        comp_mode_i <= 1'b1;
        i_host.wr(4'h4, 16'h0004);
        fire(0, 16'h2A80);
        `CHK({over_limit_live_o, alert_n_o}, 2'b10)
        fire(0, 16'h2980);
        `CHK({over_limit_live_o, alert_n_o}, 2'b10)
        fire(0, 16'h297C);
        `CHK({over_limit_live_o, alert_n_o}, 2'b01)
        i_host.wr(4'h4, 16'h0002);
        fire(0, 16'hF380);
        `CHK({under_limit_live_o, alert_n_o}, 2'b10)
        fire(0, 16'hF480);
        `CHK({under_limit_live_o, alert_n_o}, 2'b10)
        fire(0, 16'hF484);
        `CHK({under_limit_live_o, alert_n_o}, 2'b01)
        @(posedge sys_clk_i);
        margin <= 8'h0A;
        comp_mode_i <= 1'b0;
        clean();
        $display("test release margins done");
    endtask

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_sources();
        t_hold_comp();
        t_invalid();
        t_margin();
        report_and_stop();
    end
endmodule
